// ==== core/amp_fault_status_and_report.sv ====
// fault status, masking and latching register group of a class-d amplifier
//
// Overview of operation
// - left dc fault at status bit 3, right at bit 2, read-only, reset zero
// - left over-current at status bit 1, right at bit 0
// - global a bit 7 flags failed memory integrity check
// - global a bit 6 flags failed latest biquad coefficient write
// - global b bit 0 flags thermal shutdown; other bits read zero
// - warning register bit 2 flags die temperature at warning threshold
// - mask bit 7 keeps thermal shutdown off the fault report
// - mask bits 6 and 5 block logic supply under and overvoltage
// - mask bit 4 keeps clock faults off the fault report
// - mask bits 3 and 2 block power supply under and overvoltage
// - mask bits 1 and 0 block dc and over-current faults
// - latch control bit 5 holds clock fault, resets to one
// - latch control bit 4 holds thermal shutdown, resets to one
// - latch control bit 3 holds thermal warning, resets to one
// - latch control bit 2 blocks thermal warning report, resets zero
// - recovery bit 7 latches clock detect status, else it follows live
// - recovery bit 4 enables automatic thermal shutdown recovery
// - writing one to clear bit 7 clears latched analog faults

`timescale 1ns/1ps
`default_nettype none
`include "amp_fault_map.svh"

module amp_fault_status_and_report
    import amp_fault_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    // raw detector conditions
    input  wire logic       left_dc_in,
    input  wire logic       right_dc_in,
    input  wire logic       left_oc_in,
    input  wire logic       right_oc_in,
    input  wire logic       mem_check_err_in,
    input  wire logic       biquad_fail_in,
    input  wire logic       clock_fault_in,
    input  wire logic       supply_ov_in,
    input  wire logic       supply_uv_in,
    input  wire logic       logic_ov_in,
    input  wire logic       logic_uv_in,
    input  wire logic       thermal_sd_in,
    input  wire logic       thermal_warn_in,
    input  wire logic       clock_detect_in,
    // outputs
    output logic            fault_report,
    output logic            clock_detect_status,
    output logic            thermal_auto_recover,
    output logic            thermal_shutdown_active
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg_byte_t mask_q, mask_d;
    reg_byte_t latch_ctrl_q, latch_ctrl_d;
    reg_byte_t recov_q, recov_d;
    logic left_dc_fault_flag_q, left_dc_fault_flag_d;
    logic right_dc_fault_flag_q, right_dc_fault_flag_d;
    logic left_overcurrent_flag_q, left_overcurrent_flag_d;
    logic right_overcurrent_flag_q, right_overcurrent_flag_d;
    logic mem_check_flag_q, mem_check_flag_d;
    logic biquad_write_failure_flag_q, biquad_write_failure_flag_d;
    logic clock_fault_flag_q, clock_fault_flag_d;
    logic power_supply_overvoltage_flag_q, power_supply_overvoltage_flag_d;
    logic power_supply_undervoltage_flag_q, power_supply_undervoltage_flag_d;
    logic thermal_shutdown_flag_q, thermal_shutdown_flag_d;
    logic thermal_warning_flag_q, thermal_warning_flag_d;
    logic clock_detect_q, clock_detect_d;
    logic report_q, report_d;
    logic clear_hit;

    // hold or follow a condition; a live event wins over the clear
    function automatic logic hold_flag(input logic flag, input logic cond,
                                       input logic hold, input logic clr);
        hold_flag = hold ? (cond | (flag & ~clr)) : cond;
    endfunction

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    always_comb
    begin
        mask_d       = mask_q;
        latch_ctrl_d = latch_ctrl_q;
        recov_d      = recov_q;
        clear_hit    = 1'b0;
        if (reg_wr)
        begin
            case (reg_addr)
                `OFS_REPORT_MASK: mask_d       = reg_wdata;
                `OFS_LATCH_CTRL:  latch_ctrl_d = reg_wdata;
                `OFS_RECOV_CTRL:  recov_d      = reg_wdata;
                `OFS_FAULT_CLEAR: clear_hit    = reg_wdata[`B_ANALOG_CLEAR];
                default:          clear_hit    = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // fault flags
    // ------------------------------------------------------------------
    always_comb
    begin
        // analog faults hold until the clear trigger
        left_dc_fault_flag_d      = hold_flag(left_dc_fault_flag_q, left_dc_in, 1'b1,
                                              clear_hit);
        right_dc_fault_flag_d     = hold_flag(right_dc_fault_flag_q, right_dc_in, 1'b1,
                                              clear_hit);
        left_overcurrent_flag_d   = hold_flag(left_overcurrent_flag_q, left_oc_in, 1'b1,
                                              clear_hit);
        right_overcurrent_flag_d  = hold_flag(right_overcurrent_flag_q, right_oc_in, 1'b1,
                                              clear_hit);
        power_supply_overvoltage_flag_d  = hold_flag(power_supply_overvoltage_flag_q,
                                                     supply_ov_in, 1'b1, clear_hit);
        power_supply_undervoltage_flag_d = hold_flag(power_supply_undervoltage_flag_q,
                                                     supply_uv_in, 1'b1, clear_hit);
        // digital status follows its source
        mem_check_flag_d            = mem_check_err_in;
        biquad_write_failure_flag_d = biquad_fail_in;
        // selectable hold
        clock_fault_flag_d = hold_flag(clock_fault_flag_q, clock_fault_in,
                                       latch_ctrl_q[`B_HOLD_CLOCK], clear_hit);
        thermal_shutdown_flag_d = hold_flag(thermal_shutdown_flag_q, thermal_sd_in,
                                            latch_ctrl_q[`B_HOLD_SD], clear_hit);
        thermal_warning_flag_d = hold_flag(thermal_warning_flag_q, thermal_warn_in,
                                           latch_ctrl_q[`B_HOLD_WARN], clear_hit);
        clock_detect_d = hold_flag(clock_detect_q, clock_detect_in,
                                   recov_q[`B_DETECT_HOLD], clear_hit);
        // auto recovery releases a held shutdown once the die cools
        if (recov_q[`B_AUTO_RECOVER] && !thermal_sd_in)
        begin
            thermal_shutdown_flag_d = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // fault report, masked sources other than logic supply still visible in status
    // ------------------------------------------------------------------
    always_comb
    begin
        report_d = 1'b0;
        if (!mask_q[`B_MASK_SD] && thermal_shutdown_flag_q) report_d = 1'b1;
        if (!mask_q[`B_MASK_LOGIC_UV] && logic_uv_in) report_d = 1'b1;
        if (!mask_q[`B_MASK_LOGIC_OV] && logic_ov_in) report_d = 1'b1;
        if (!mask_q[`B_MASK_CLOCK] && clock_fault_flag_q) report_d = 1'b1;
        if (!mask_q[`B_MASK_PWR_UV] && power_supply_undervoltage_flag_q)
            report_d = 1'b1;
        if (!mask_q[`B_MASK_PWR_OV] && power_supply_overvoltage_flag_q)
            report_d = 1'b1;
        if (!mask_q[`B_DC_FAULT_REPORT_BLOCK] && (left_dc_fault_flag_q || right_dc_fault_flag_q))
            report_d = 1'b1;
        if (!mask_q[`B_OVERCURRENT_REPORT_BLOCK] && (left_overcurrent_flag_q || right_overcurrent_flag_q))
            report_d = 1'b1;
        if (!latch_ctrl_q[`B_MASK_WARN] && thermal_warning_flag_q) report_d = 1'b1;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            mask_q                           <= `RST_REPORT_MASK;
            latch_ctrl_q                     <= `RST_LATCH_CTRL;
            recov_q                          <= `RST_ZERO;
            left_dc_fault_flag_q             <= 1'b0;
            right_dc_fault_flag_q            <= 1'b0;
            left_overcurrent_flag_q          <= 1'b0;
            right_overcurrent_flag_q         <= 1'b0;
            mem_check_flag_q                 <= 1'b0;
            biquad_write_failure_flag_q      <= 1'b0;
            clock_fault_flag_q               <= 1'b0;
            power_supply_overvoltage_flag_q  <= 1'b0;
            power_supply_undervoltage_flag_q <= 1'b0;
            thermal_shutdown_flag_q          <= 1'b0;
            thermal_warning_flag_q           <= 1'b0;
            clock_detect_q                   <= 1'b0;
            report_q                         <= 1'b0;
        end
        else
        begin
            mask_q                           <= mask_d;
            latch_ctrl_q                     <= latch_ctrl_d;
            recov_q                          <= recov_d;
            left_dc_fault_flag_q             <= left_dc_fault_flag_d;
            right_dc_fault_flag_q            <= right_dc_fault_flag_d;
            left_overcurrent_flag_q          <= left_overcurrent_flag_d;
            right_overcurrent_flag_q         <= right_overcurrent_flag_d;
            mem_check_flag_q                 <= mem_check_flag_d;
            biquad_write_failure_flag_q      <= biquad_write_failure_flag_d;
            clock_fault_flag_q               <= clock_fault_flag_d;
            power_supply_overvoltage_flag_q  <= power_supply_overvoltage_flag_d;
            power_supply_undervoltage_flag_q <= power_supply_undervoltage_flag_d;
            thermal_shutdown_flag_q          <= thermal_shutdown_flag_d;
            thermal_warning_flag_q           <= thermal_warning_flag_d;
            clock_detect_q                   <= clock_detect_d;
            report_q                         <= report_d;
        end
    end

    // ------------------------------------------------------------------
    // read mux, reserved bits read zero
    // ------------------------------------------------------------------
    always_comb
    begin
        reg_rdata = `RST_ZERO;
        case (reg_addr)
            `OFS_CHAN_STATUS:
            begin
                reg_rdata[`B_LEFT_DC]  = left_dc_fault_flag_q;
                reg_rdata[`B_RIGHT_DC] = right_dc_fault_flag_q;
                reg_rdata[`B_LEFT_OC]  = left_overcurrent_flag_q;
                reg_rdata[`B_RIGHT_OC] = right_overcurrent_flag_q;
            end
            `OFS_GLOBAL_A:
            begin
                reg_rdata[`B_MEM_CHECK]   = mem_check_flag_q;
                reg_rdata[`B_BIQUAD_FAIL] = biquad_write_failure_flag_q;
                reg_rdata[`B_CLOCK_FAULT] = clock_fault_flag_q;
                reg_rdata[`B_SUPPLY_OV]   = power_supply_overvoltage_flag_q;
                reg_rdata[`B_SUPPLY_UV]   = power_supply_undervoltage_flag_q;
            end
            `OFS_GLOBAL_B:   reg_rdata[`B_THERMAL_SD] = thermal_shutdown_flag_q;
            `OFS_TEMP_WARN:  reg_rdata[`B_THERMAL_WARN] = thermal_warning_flag_q;
            `OFS_REPORT_MASK: reg_rdata = mask_q;
            `OFS_LATCH_CTRL:  reg_rdata = latch_ctrl_q;
            `OFS_RECOV_CTRL:  reg_rdata = recov_q;
            default:          reg_rdata = `RST_ZERO;
        endcase
    end

    // outputs straight from flops
    assign fault_report            = report_q;
    assign clock_detect_status     = clock_detect_q;
    assign thermal_auto_recover    = recov_q[`B_AUTO_RECOVER];
    assign thermal_shutdown_active = thermal_shutdown_flag_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_dc_left_hold: assert property (left_dc_in |=> left_dc_fault_flag_q)
        else $error("left dc flag not set");
    a_oc_right_hold: assert property (right_oc_in |=> right_overcurrent_flag_q)
        else $error("right oc flag not set");
    a_mem_check_bit: assert property (
        mem_check_err_in |=> (reg_addr != `OFS_GLOBAL_A || reg_rdata[`B_MEM_CHECK]))
        else $error("memory check bit missing");
    a_biquad_track: assert property (biquad_fail_in |=> biquad_write_failure_flag_q)
        else $error("biquad flag wrong");
    a_global_b_zero: assert property (
        reg_addr == `OFS_GLOBAL_B |-> reg_rdata[7:1] == 7'h00)
        else $error("global b reserved bits set");
    a_warn_read: assert property (
        reg_addr == `OFS_TEMP_WARN |-> reg_rdata[`B_THERMAL_WARN] == thermal_warning_flag_q)
        else $error("warning bit mismatch");
    a_sd_masked: assert property (
        mask_q == 8'hff && latch_ctrl_q[`B_MASK_WARN] |=> !fault_report)
        else $error("masked fault reported");
    a_oc_reported: assert property (
        right_overcurrent_flag_q && !mask_q[`B_OVERCURRENT_REPORT_BLOCK] |=> fault_report)
        else $error("unmasked fault not reported");
    a_clear_drops: assert property (
        clear_hit && !left_dc_in ##1 !left_dc_in |-> !left_dc_fault_flag_q)
        else $error("clear did not drop flag");
    a_sd_follow: assert property (
        !latch_ctrl_q[`B_HOLD_SD] && !thermal_sd_in |=> !thermal_shutdown_flag_q)
        else $error("unlatched shutdown held");
    a_auto_recover: assert property (
        recov_q[`B_AUTO_RECOVER] && !thermal_sd_in |=> !thermal_shutdown_flag_q)
        else $error("no auto recovery");
    a_detect_follow: assert property (
        !recov_q[`B_DETECT_HOLD] |=> clock_detect_q == $past(clock_detect_in))
        else $error("detect status not live");
    // held flags survive without a clear; unmasked logic and power undervoltage reach the report
    a_clock_hold: assert property (
        latch_ctrl_q[`B_HOLD_CLOCK] && clock_fault_flag_q && !clear_hit |=> clock_fault_flag_q)
        else $error("held clock fault dropped");
    a_warn_hold: assert property (
        latch_ctrl_q[`B_HOLD_WARN] && thermal_warning_flag_q && !clear_hit
        |=> thermal_warning_flag_q)
        else $error("held warning dropped");
    a_logic_uv_report: assert property (
        logic_uv_in && !mask_q[`B_MASK_LOGIC_UV] |=> fault_report)
        else $error("logic undervoltage not reported");
    a_pwr_uv_report: assert property (
        power_supply_undervoltage_flag_q && !mask_q[`B_MASK_PWR_UV] |=> fault_report)
        else $error("power undervoltage not reported");

    c_fault_report: cover property (left_dc_in ##1 fault_report);
    c_clear_write:  cover property (clear_hit ##1 !left_dc_fault_flag_q);
    c_auto_recover: cover property (thermal_shutdown_flag_q ##1 !thermal_shutdown_flag_q);
    c_set_wins:     cover property (clear_hit && left_dc_in ##1 left_dc_fault_flag_q);

endmodule

`default_nettype wire

// ==== core/amp_fault_map.svh ====
// register offsets, field positions and reset values of the fault register group
`ifndef AMP_FAULT_MAP_SVH
`define AMP_FAULT_MAP_SVH

`define OFS_CHAN_STATUS   8'h70
`define OFS_GLOBAL_A      8'h71
`define OFS_GLOBAL_B      8'h72
`define OFS_TEMP_WARN     8'h73
`define OFS_REPORT_MASK   8'h74
`define OFS_LATCH_CTRL    8'h75
`define OFS_RECOV_CTRL    8'h76
`define OFS_FAULT_CLEAR   8'h78

`define RST_REPORT_MASK   8'h00
`define RST_ZERO          8'h00
`define RST_LATCH_CTRL    8'hf8

// channel status fields
`define B_LEFT_DC         3
`define B_RIGHT_DC        2
`define B_LEFT_OC         1
`define B_RIGHT_OC        0
// global status a fields
`define B_MEM_CHECK       7
`define B_BIQUAD_FAIL     6
`define B_CLOCK_FAULT     2
`define B_SUPPLY_OV       1
`define B_SUPPLY_UV       0
// global status b / warning fields
`define B_THERMAL_SD      0
`define B_THERMAL_WARN    2
// report mask fields
`define B_MASK_SD         7
`define B_MASK_LOGIC_UV   6
`define B_MASK_LOGIC_OV   5
`define B_MASK_CLOCK      4
`define B_MASK_PWR_UV     3
`define B_MASK_PWR_OV     2
`define B_DC_FAULT_REPORT_BLOCK         1
`define B_OVERCURRENT_REPORT_BLOCK         0
// latch control fields
`define B_HOLD_CLOCK      5
`define B_HOLD_SD         4
`define B_HOLD_WARN       3
`define B_MASK_WARN       2
// recovery and detect control fields
`define B_DETECT_HOLD     7
`define B_AUTO_RECOVER    4
// fault clear trigger
`define B_ANALOG_CLEAR    7

`endif

// ==== core/amp_fault_pkg.sv ====
// types shared by the fault register group
`default_nettype none
package amp_fault_pkg;
    typedef logic [7:0] reg_byte_t;
endpackage
`default_nettype wire

// ==== dv/amp_fault_status_and_report_tb.sv ====
// self-checking testbench for the fault status, masking and latching register group
`timescale 1ns/1ps
`default_nettype none

module amp_fault_status_and_report_tb
    import amp_fault_pkg::*;
();

    // ----------------------------------------------------------------
    // stimulus signals
    // ----------------------------------------------------------------
    logic        clk_sys;
    logic        rst;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic [7:0]  reg_wdata;
    reg_byte_t   reg_rdata;
    logic [12:0] cond;
    logic        clock_detect_in;
    logic        fault_report;
    logic        clock_detect_status;
    logic        thermal_auto_recover;
    logic        thermal_shutdown_active;
    int          n_errors;
    int          compares;
    int          cycles;
    // status place and report mask bit of each condition: offset (00 when none), bit, mask bit
    logic [7:0]  st_ofs [13] = '{8'h70, 8'h70, 8'h70, 8'h70, 8'h71, 8'h71, 8'h71,
                                 8'h71, 8'h71, 8'h00, 8'h00, 8'h72, 8'h73};
    int          st_bit [13] = '{3, 2, 1, 0, 7, 6, 2, 1, 0, 0, 0, 0, 2};
    int          mk_bit [13] = '{1, 1, 0, 0, 0, 0, 4, 2, 3, 5, 6, 7, 2};

    // ----------------------------------------------------------------
    // device under test
    // ----------------------------------------------------------------
    amp_fault_status_and_report uut (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .left_dc_in(cond[0]), .right_dc_in(cond[1]), .left_oc_in(cond[2]),
        .right_oc_in(cond[3]), .mem_check_err_in(cond[4]), .biquad_fail_in(cond[5]),
        .clock_fault_in(cond[6]), .supply_ov_in(cond[7]), .supply_uv_in(cond[8]),
        .logic_ov_in(cond[9]), .logic_uv_in(cond[10]), .thermal_sd_in(cond[11]),
        .thermal_warn_in(cond[12]), .clock_detect_in(clock_detect_in),
        .fault_report(fault_report), .clock_detect_status(clock_detect_status),
        .thermal_auto_recover(thermal_auto_recover),
        .thermal_shutdown_active(thermal_shutdown_active)
    );

    // ----------------------------------------------------------------
    // clock and hang guard
    // ----------------------------------------------------------------
    always #50 clk_sys = ~clk_sys;

    // whole run needs well under a thousand cycles
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk8(input reg_byte_t got, input reg_byte_t exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // n edges, then settle on the falling edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input reg_byte_t e);
        @(posedge clk_sys);
        reg_addr <= a;
        @(negedge clk_sys);
        chk8(reg_rdata, e);
    endtask

    task automatic setc(input int i, input logic v);
        @(posedge clk_sys);
        cond[i] <= v;
    endtask

    task automatic setd(input logic v);
        @(posedge clk_sys);
        clock_detect_in <= v;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0; rst = 1'b1; reg_addr = 8'h00; reg_wr = 1'b0;
        reg_wdata = 8'h00; cond = '0; clock_detect_in = 1'b0;
        n_errors = 0; compares = 0; cycles = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        // reset values and read-only places
        rd(8'h70, 8'h00); rd(8'h71, 8'h00); rd(8'h72, 8'h00);
        rd(8'h73, 8'h00); rd(8'h74, 8'h00); rd(8'h76, 8'h00);
        rd(8'h75, 8'hf8);
        wr(8'h70, 8'hff); rd(8'h70, 8'h00);
        wr(8'h72, 8'hff); rd(8'h72, 8'h00);
        chk1(fault_report, 1'b0);
        $display("test reset done");
        // each class but memory check and biquad: blocked, then reported, held (logic supply faults drop), then cleared
        for (int i = 0; i < 13; i++)
        begin
            if (i == 4 || i == 5) continue;
            if (i == 12) wr(8'h75, 8'hfc);
            else wr(8'h74, reg_byte_t'(1) << mk_bit[i]);
            setc(i, 1'b1); cyc(3);
            chk1(fault_report, 1'b0);
            if (st_ofs[i] != 8'h00) rd(st_ofs[i], reg_byte_t'(1) << st_bit[i]);
            if (i == 12) wr(8'h75, 8'hf8);
            else wr(8'h74, 8'h00);
            cyc(2);
            chk1(fault_report, 1'b1);
            setc(i, 1'b0); cyc(3);
            chk1(fault_report, (i != 9 && i != 10));
            if (st_ofs[i] != 8'h00) rd(st_ofs[i], reg_byte_t'(1) << st_bit[i]);
            wr(8'h78, 8'h80); cyc(2);
            chk1(fault_report, 1'b0);
            if (st_ofs[i] != 8'h00) rd(st_ofs[i], 8'h00);
        end
        $display("test mask and hold done");
        // a clear in the same cycle as a live fault leaves the flag set
        setc(0, 1'b1); wr(8'h78, 8'h80); cyc(1);
        rd(8'h70, 8'h08);
        setc(0, 1'b0); wr(8'h78, 8'h80); cyc(1);
        rd(8'h70, 8'h00);
        $display("test set wins done");
        // memory check and biquad flags track their source
        setc(4, 1'b1); setc(5, 1'b1); cyc(2);
        rd(8'h71, 8'hc0);
        setc(4, 1'b0); setc(5, 1'b0); cyc(2);
        rd(8'h71, 8'h00);
        $display("test digital flags done");
        // holds off: clock, shutdown, warning track the condition
        wr(8'h75, 8'hc0); rd(8'h75, 8'hc0);
        setc(6, 1'b1); setc(11, 1'b1); setc(12, 1'b1); cyc(2);
        rd(8'h71, 8'h04); rd(8'h72, 8'h01); rd(8'h73, 8'h04);
        setc(6, 1'b0); setc(11, 1'b0); setc(12, 1'b0); cyc(2);
        rd(8'h71, 8'h00); rd(8'h72, 8'h00); rd(8'h73, 8'h00);
        wr(8'h75, 8'hf8);
        $display("test hold disable done");
        // clock detect status: live, then held until clear
        setd(1'b1); cyc(3);
        chk1(clock_detect_status, 1'b1);
        setd(1'b0); cyc(3);
        chk1(clock_detect_status, 1'b0);
        wr(8'h76, 8'h80); rd(8'h76, 8'h80);
        setd(1'b1); cyc(3);
        setd(1'b0); cyc(3);
        chk1(clock_detect_status, 1'b1);
        wr(8'h78, 8'h80); cyc(2);
        chk1(clock_detect_status, 1'b0);
        $display("test clock detect done");
        // automatic recovery from thermal shutdown, then none
        wr(8'h76, 8'h10); cyc(2);
        chk1(thermal_auto_recover, 1'b1);
        setc(11, 1'b1); cyc(3);
        chk1(thermal_shutdown_active, 1'b1);
        setc(11, 1'b0); cyc(3);
        chk1(thermal_shutdown_active, 1'b0);
        wr(8'h76, 8'h00); cyc(2);
        chk1(thermal_auto_recover, 1'b0);
        setc(11, 1'b1); cyc(3);
        setc(11, 1'b0); cyc(3);
        chk1(thermal_shutdown_active, 1'b1);
        wr(8'h78, 8'h80); cyc(2);
        chk1(thermal_shutdown_active, 1'b0);
        rd(8'h77, 8'h00); rd(8'h78, 8'h00);
        $display("test recovery done");
        // mid-run reset returns the control registers to their reset values
        wr(8'h74, 8'h55); wr(8'h76, 8'h90); wr(8'h75, 8'h00);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(8'h74, 8'h00); rd(8'h76, 8'h00);
        rd(8'h75, 8'hf8);
        chk1(thermal_auto_recover, 1'b0);
        $display("test mid reset done");
        final_report();
    end
endmodule

`default_nettype wire
